// file: hw/ums_pkg.sv
// Purpose: constants for the uart line and modem status block
// Assumes: 8-bit registers on a plain address/strobe port
// Notes: offsets follow a conventional uart register map
package ums_pkg;
   localparam logic [2:0] ADDR_HOLD = 3'h0;
   localparam logic [2:0] ADDR_IER = 3'h1;
   localparam logic [2:0] ADDR_EFR = 3'h2;
   localparam logic [2:0] ADDR_CTRL = 3'h3;
   localparam logic [2:0] ADDR_MCR = 3'h4;
   localparam logic [2:0] ADDR_LSR = 3'h5;
   localparam logic [2:0] ADDR_MSR = 3'h6;
   localparam logic [2:0] ADDR_FLOW = 3'h7;
   localparam int MCR_DTR = 0;
   localparam int MCR_RTS = 1;
   localparam int MCR_OP1 = 2;
   localparam int MCR_OP2 = 3;
   localparam int MCR_LOOP = 4;
   localparam int MCR_XANY = 5;
   localparam int MCR_IRDA = 6;
   localparam int MCR_PRESC = 7;
   localparam int EFR_ENH = 4;
   localparam int EFR_ACTS = 7;
   localparam int IER_MSI = 3;
   localparam int CTRL_FIFO = 0;
   localparam int CTRL_PAR = 1;
   localparam int CTRL_ODDP = 2;
   localparam int CTRL_SWFC = 3;
   localparam logic [7:0] MCR_RESET = 8'h00;
   localparam logic [7:0] EFR_RESET = 8'h00;
   localparam logic [7:0] IER_RESET = 8'h00;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] XON_RESET = 8'h11;
   localparam logic [7:0] XOFF_RESET = 8'h13;
   localparam int FIFO_DEPTH = 32;
   localparam int PTR_W = 5;
   localparam int PRESC_DIV = 4;
   localparam int BAUD_DIV = 16;
   localparam logic [3:0] FRAME_BITS = 4'hA;
   typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} ums_tx_type;
   typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_BREAK} ums_rx_type;
endpackage

// file: hw/ums_uart_status.sv
// Purpose: one uart channel with line/modem status and upper mcr options
// Assumes: pins synchronous inputs except modem pins (synchronised here)
// Notes: 8 data bits, one stop bit; optional rx parity takes the place of data bit 7; fixed baud divider
// Summary of operation
// [RL1] any-char resume mode restarts a transmitter halted by xoff
// [RL2] resume char still stored unless it is an xon/xoff in sw flow
// [RL3] resume, infrared, prescaler bits writable only with enhanced enable
// [RL4] infrared enable routes tx and rx through the encoder and decoder
// [RL5] infrared tx output rests low when idle
// [RL6] prescaler bit selects clock or clock divided by four; reset zero
// [RL7] receive-ready reads one while a character waits in the fifo
// [RL8] full fifo on new character sets overrun and drops the character
// [RL9] parity flag belongs to the character at the read position
// [RL10] framing flag belongs to the character at the read position
// [RL11] line low for a frame flags break; one break char per break
// [RL12] holding-empty sets on hand-off to shifter, clears on host write
// [RL13] transmitter-empty only when holding storage and shifter empty
// [RL14] fifo error bit set while any stored char has an error
// [RL15] cts, dsr, cd change flags set on any toggle since last read
// [RL16] ring change flag sets only on low-to-high of ring input
// [RL17] any change flag raises modem interrupt when enabled
// [RL18] auto cts: high input halts tx after current char, low resumes
// [RL19] cts status is inverse of pin, or rts bit in loopback
// [RL20] upper modem status bits are levels, lower bits are changes
// [RL21] enhanced enable clear latches upper modem control bits
// [RL22] loopback redirects modem control outputs to status inputs
// [RL23] infrared rx polarity bit: zero active high, one active low
// [RL24] modem status read clears change flags; line status read clears overrun
// [RL25] modem inputs synchronised before edge detection
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
module ums_uart_status (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic rx,
   output logic tx,
   input wire logic cts_n,
   input wire logic dsr_n,
   input wire logic ring_indicator_n,
   input wire logic carrier_detect_n,
   output logic rts_n,
   output logic dtr_n,
   output logic legacy_output_one_n,
   output logic op2_n,
   output logic modem_irq
);
   logic [7:0] modem_control_reg, enhanced_feature_reg;
   logic [7:0] interrupt_enable_reg, ctrl_reg, xon_reg, xoff_reg;
   logic [7:0] rdata_reg;
   // receive fifo: data plus parity, framing, break tags
   logic [10:0] rx_mem [ums_pkg::FIFO_DEPTH];
   logic [ums_pkg::PTR_W-1:0] rd_ptr_reg, wr_ptr_reg;
   logic [ums_pkg::PTR_W:0] count_reg;
   logic [ums_pkg::PTR_W:0] err_count_reg;
   logic overrun_reg;
   logic [7:0] hold_reg;
   logic hold_full_reg;
   logic [9:0] shift_reg;
   logic [3:0] tx_bits_reg;
   ums_pkg::ums_tx_type tx_state_reg;
   logic xoff_halt_reg;
   logic [1:0] presc_reg;
   logic [3:0] baud_reg;
   logic tick;
   logic [3:0] sync1_reg, sync2_reg, prev_reg, delta_reg;
   logic [3:0] pin_level;
   ums_pkg::ums_rx_type rx_state_reg;
   logic [3:0] rx_bits_reg;
   logic [9:0] rx_shift_reg;
   logic rx_line, tx_line, loop;
   logic rx_done;
   logic [10:0] rx_word;
   logic store;
   logic fifo_pop;
   logic lsr_rd, msr_rd;
   logic enh;
   logic [7:0] lsr_val, msr_val;

   function automatic logic err_of(input logic [10:0] w);
      return |w[10:8];
   endfunction

   assign enh = enhanced_feature_reg[ums_pkg::EFR_ENH];
   assign loop = modem_control_reg[ums_pkg::MCR_LOOP];
   assign lsr_rd = rd && addr == ums_pkg::ADDR_LSR;
   assign msr_rd = rd && addr == ums_pkg::ADDR_MSR;
   assign fifo_pop = rd && addr == ums_pkg::ADDR_HOLD && count_reg != '0;

   // host registers; upper mcr bits freeze while enhanced enable is clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         modem_control_reg <= ums_pkg::MCR_RESET;
         enhanced_feature_reg <= ums_pkg::EFR_RESET;
         interrupt_enable_reg <= ums_pkg::IER_RESET;
         ctrl_reg <= ums_pkg::CTRL_RESET;
         xon_reg <= ums_pkg::XON_RESET;
         xoff_reg <= ums_pkg::XOFF_RESET;
      end else if (wr) begin
         unique case (addr)
            ums_pkg::ADDR_MCR: begin
               modem_control_reg[4:0] <= wdata[4:0];
               if (enh) begin
                  modem_control_reg[7:5] <= wdata[7:5]; // RL3 RL21
               end
            end
            ums_pkg::ADDR_EFR: enhanced_feature_reg <= wdata;
            ums_pkg::ADDR_IER: interrupt_enable_reg <= wdata;
            ums_pkg::ADDR_CTRL: ctrl_reg <= wdata;
            ums_pkg::ADDR_FLOW: begin
               xon_reg <= wdata;
               xoff_reg <= ~wdata;
            end
            default: ;
         endcase
      end
   end

   // prescaler and divide-by-16 baud tick, one tick per bit
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         presc_reg <= '0;
         baud_reg <= '0;
      end else begin
         presc_reg <= presc_reg + 2'h1;
         if (!modem_control_reg[ums_pkg::MCR_PRESC] || presc_reg == 2'h3) begin
            baud_reg <= baud_reg + 4'h1; // RL6
         end
      end
   end
   assign tick = baud_reg == 4'hF &&
      (!modem_control_reg[ums_pkg::MCR_PRESC] || presc_reg == 2'h3);

   // receive line: loopback, then irda decode with selectable polarity
   always_comb begin
      if (loop) begin
         rx_line = tx_line; // RL22
      end else if (modem_control_reg[ums_pkg::MCR_IRDA]) begin
         rx_line = modem_control_reg[ums_pkg::MCR_OP1] ? !rx : rx; // RL4 RL23
         rx_line = !rx_line;
      end else begin
         rx_line = rx;
      end
   end

   // receiver: one bit per tick, break held until line returns high
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_state_reg <= ums_pkg::RX_IDLE;
         rx_bits_reg <= '0;
         rx_shift_reg <= '0;
      end else if (tick) begin
         unique case (rx_state_reg)
            ums_pkg::RX_IDLE: if (!rx_line) begin
               rx_state_reg <= ums_pkg::RX_SHIFT;
               rx_bits_reg <= '0;
            end
            ums_pkg::RX_SHIFT: begin
               rx_shift_reg <= {rx_line, rx_shift_reg[9:1]};
               rx_bits_reg <= rx_bits_reg + 4'h1;
               // start was sampled in idle, so nine samples end the frame
               if (rx_bits_reg == ums_pkg::FRAME_BITS - 4'h2) begin
                  rx_state_reg <= (rx_shift_reg[9:2] == '0 && !rx_line) ?
                     ums_pkg::RX_BREAK : ums_pkg::RX_IDLE;
               end
            end
            ums_pkg::RX_BREAK: if (rx_line) begin
               rx_state_reg <= ums_pkg::RX_IDLE; // RL11
            end
            default: rx_state_reg <= ums_pkg::RX_IDLE;
         endcase
      end
   end
   assign rx_done = tick && rx_state_reg == ums_pkg::RX_SHIFT &&
      rx_bits_reg == ums_pkg::FRAME_BITS - 4'h2;

   // word: [10] break, [9] framing, [8] parity, [7:0] data
   always_comb begin
      rx_word[7:0] = ctrl_reg[ums_pkg::CTRL_PAR] ?
         {1'b0, rx_shift_reg[8:2]} : rx_shift_reg[9:2];
      rx_word[10] = rx_shift_reg[9:2] == '0 && !rx_line; // RL11
      rx_word[9] = !rx_line && !rx_word[10]; // RL10
      rx_word[8] = ctrl_reg[ums_pkg::CTRL_PAR] && !rx_word[10] &&
         ((^rx_shift_reg[9:2]) ^ ctrl_reg[ums_pkg::CTRL_ODDP]); // RL9
   end

   // xon/xoff characters are swallowed only under sw flow control
   assign store = rx_done && !(ctrl_reg[ums_pkg::CTRL_SWFC] &&
      (rx_word[7:0] == xon_reg || rx_word[7:0] == xoff_reg)); // RL2

   // receive fifo with error count; a full fifo drops the new character
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_ptr_reg <= '0;
         wr_ptr_reg <= '0;
         count_reg <= '0;
         err_count_reg <= '0;
      end else begin
         if (store && count_reg != ums_pkg::FIFO_DEPTH) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (fifo_pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg
            + (store && count_reg != ums_pkg::FIFO_DEPTH)
            - fifo_pop;
         err_count_reg <= err_count_reg
            + (store && count_reg != ums_pkg::FIFO_DEPTH && err_of(rx_word))
            - (fifo_pop && err_of(rx_mem[rd_ptr_reg])); // RL14
      end
   end
   always_ff @(posedge clk) begin
      if (store && count_reg != ums_pkg::FIFO_DEPTH) begin
         rx_mem[wr_ptr_reg] <= rx_word;
      end
   end

   // overrun: set wins over the clear by a status read
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         overrun_reg <= 1'b0;
      end else if (store && count_reg == ums_pkg::FIFO_DEPTH) begin
         overrun_reg <= 1'b1; // RL8
      end else if (lsr_rd) begin
         overrun_reg <= 1'b0; // RL24
      end
   end

   // software (xon/xoff) flow control of the transmitter
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         xoff_halt_reg <= 1'b0;
      end else if (rx_done && ctrl_reg[ums_pkg::CTRL_SWFC] &&
                   rx_word[7:0] == xoff_reg) begin
         xoff_halt_reg <= 1'b1;
      end else if (rx_done && (rx_word[7:0] == xon_reg ||
                   modem_control_reg[ums_pkg::MCR_XANY])) begin
         xoff_halt_reg <= 1'b0; // RL1
      end
   end

   // holding register and shifter; cts checked only between characters
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hold_reg <= '0;
         hold_full_reg <= 1'b0;
         shift_reg <= '1;
         tx_bits_reg <= '0;
         tx_state_reg <= ums_pkg::TX_IDLE;
      end else begin
         if (wr && addr == ums_pkg::ADDR_HOLD) begin
            hold_reg <= wdata;
            hold_full_reg <= 1'b1; // RL12
         // load only on a tick so the start bit lasts a full bit time
         end else if (tick && tx_state_reg == ums_pkg::TX_IDLE &&
                      hold_full_reg && !xoff_halt_reg &&
                      !(enhanced_feature_reg[ums_pkg::EFR_ACTS] &&
                      !msr_val[4])) begin // RL18
            hold_full_reg <= 1'b0; // RL12
            shift_reg <= {1'b1, hold_reg, 1'b0};
            tx_bits_reg <= '0;
            tx_state_reg <= ums_pkg::TX_SHIFT;
         end
         if (tick && tx_state_reg == ums_pkg::TX_SHIFT) begin
            shift_reg <= {1'b1, shift_reg[9:1]};
            tx_bits_reg <= tx_bits_reg + 4'h1;
            if (tx_bits_reg == ums_pkg::FRAME_BITS - 4'h1) begin
               tx_state_reg <= ums_pkg::TX_IDLE;
            end
         end
      end
   end
   assign tx_line = shift_reg[0];

   // irda pulse while a zero bit is sent, low when idle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tx <= 1'b1;
      end else if (loop) begin
         tx <= 1'b1;
      end else if (modem_control_reg[ums_pkg::MCR_IRDA]) begin
         tx <= tx_state_reg == ums_pkg::TX_SHIFT && !tx_line &&
            baud_reg[3:2] == 2'h1; // RL4 RL5
      end else begin
         tx <= tx_line;
      end
   end

   // modem pins: synchroniser, then change detection
   always_comb begin
      if (loop) begin
         pin_level = {modem_control_reg[ums_pkg::MCR_OP2],
                      modem_control_reg[ums_pkg::MCR_OP1],
                      modem_control_reg[ums_pkg::MCR_DTR],
                      modem_control_reg[ums_pkg::MCR_RTS]}; // RL19 RL22
      end else begin
         pin_level = ~sync2_reg; // RL19
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync1_reg <= '1;
         sync2_reg <= '1;
         prev_reg <= '0;
         delta_reg <= '0;
      end else begin
         sync1_reg <= {carrier_detect_n, ring_indicator_n, dsr_n, cts_n};
         sync2_reg <= sync1_reg; // RL25
         prev_reg <= pin_level;
         for (int i = 0; i < 4; i++) begin
            if (i == 2 ? (prev_reg[i] && !pin_level[i])
                       : (prev_reg[i] != pin_level[i])) begin
               delta_reg[i] <= 1'b1; // RL15 RL16
            end else if (msr_rd) begin
               delta_reg[i] <= 1'b0; // RL24
            end
         end
      end
   end

   assign msr_val = {pin_level, delta_reg}; // RL20
   assign lsr_val = {err_count_reg != '0, // RL14
      !hold_full_reg && tx_state_reg == ums_pkg::TX_IDLE, // RL13
      !hold_full_reg, // RL12
      count_reg != '0 && rx_mem[rd_ptr_reg][10], // RL11
      count_reg != '0 && rx_mem[rd_ptr_reg][9], // RL10
      count_reg != '0 && rx_mem[rd_ptr_reg][8], // RL9
      overrun_reg, count_reg != '0}; // RL7

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_reg <= '0;
      end else if (rd) begin
         unique case (addr)
            ums_pkg::ADDR_HOLD: rdata_reg <= rx_mem[rd_ptr_reg][7:0];
            ums_pkg::ADDR_IER: rdata_reg <= interrupt_enable_reg;
            ums_pkg::ADDR_EFR: rdata_reg <= enhanced_feature_reg;
            ums_pkg::ADDR_CTRL: rdata_reg <= ctrl_reg;
            ums_pkg::ADDR_MCR: rdata_reg <= modem_control_reg;
            ums_pkg::ADDR_LSR: rdata_reg <= lsr_val;
            ums_pkg::ADDR_MSR: rdata_reg <= msr_val;
            ums_pkg::ADDR_FLOW: rdata_reg <= xon_reg;
            default: rdata_reg <= '0;
         endcase
      end else begin
         rdata_reg <= '0;
      end
   end
   assign rdata = rdata_reg;

   // modem control outputs forced inactive in loopback; modem_irq is not
   assign rts_n = loop | ~modem_control_reg[ums_pkg::MCR_RTS];
   assign dtr_n = loop | ~modem_control_reg[ums_pkg::MCR_DTR];
   assign legacy_output_one_n = loop | ~modem_control_reg[ums_pkg::MCR_OP1];
   assign op2_n = loop | ~modem_control_reg[ums_pkg::MCR_OP2];
   assign modem_irq = interrupt_enable_reg[ums_pkg::IER_MSI] &&
      (delta_reg != '0); // RL17
endmodule

// file: verif/ums_status_props.sv
// Purpose: port-level checks for the uart line and modem status block
// Assumes: register shadows follow host writes on the plain bus
// Notes: pin checks wait for a quiet pin window to cover synchroniser lag
`timescale 1ns/1ns
module ums_status_props (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic rx,
   input wire logic tx,
   input wire logic cts_n,
   input wire logic dsr_n,
   input wire logic ring_indicator_n,
   input wire logic carrier_detect_n,
   input wire logic rts_n,
   input wire logic dtr_n,
   input wire logic legacy_output_one_n,
   input wire logic op2_n,
   input wire logic modem_irq
);
   logic [7:0] efr_reg, ier_reg, mcr_reg;
   logic [3:0] pins, pins_reg;
   logic [2:0] stab_reg;
   assign pins = {carrier_detect_n, ring_indicator_n, dsr_n, cts_n};
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         efr_reg <= ums_pkg::EFR_RESET;
         ier_reg <= ums_pkg::IER_RESET;
         mcr_reg <= ums_pkg::MCR_RESET;
      end else if (wr) begin
         if (addr == ums_pkg::ADDR_EFR)
            efr_reg <= wdata;
         if (addr == ums_pkg::ADDR_IER)
            ier_reg <= wdata;
         if (addr == ums_pkg::ADDR_MCR)
            mcr_reg <= efr_reg[4] ? wdata : {mcr_reg[7:5], wdata[4:0]};
      end
   end
   // quiet-pin age; a pin edge in flight would make msr reads ambiguous
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pins_reg <= 4'hF;
         stab_reg <= 3'h0;
      end else begin
         pins_reg <= pins;
         if (pins != pins_reg)
            stab_reg <= 3'h0;
         else if (stab_reg != 3'h7)
            stab_reg <= stab_reg + 3'h1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence msr_rd;
      rd && addr == ums_pkg::ADDR_MSR && stab_reg >= 3'h6;
   endsequence
   rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
      else $error("read data not zero outside a read");
   outs_map_a: assert property (!mcr_reg[4] |->
      {op2_n, legacy_output_one_n, rts_n, dtr_n} == ~mcr_reg[3:0])
      else $error("control outputs differ from modem control");
   loop_outs_a: assert property (mcr_reg[4] |->
      &{op2_n, legacy_output_one_n, rts_n, dtr_n})
      else $error("control outputs not high in loopback");
   mcr_read_a: assert property (rd && addr == ums_pkg::ADDR_MCR
      |=> rdata == $past(mcr_reg)) else $error("modem control read wrong");
   irq_mask_a: assert property (!ier_reg[3] && !$past(ier_reg[3])
      |-> !modem_irq) else $error("modem irq while disabled");
   irq_clear_a: assert property (msr_rd |-> ##2 !modem_irq)
      else $error("modem irq stays after status read");
   flags_clear_a: assert property (msr_rd ##2 msr_rd
      |=> rdata[3:0] == 4'h0) else $error("change flags not cleared");
   msr_level_a: assert property (msr_rd and !mcr_reg[4]
      |=> rdata[7:4] == ~$past(pins)) else $error("modem levels wrong");
   irda_pulse_a: assert property (mcr_reg[6] && !mcr_reg[4] && !mcr_reg[7]
      && $rose(tx) |=> tx [*3] ##1 !tx)
      else $error("infrared pulse not four clocks");
endmodule
bind ums_uart_status ums_status_props i_props (.clk(clk), .resetn(resetn),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx(rx),
   .tx(tx), .cts_n(cts_n), .dsr_n(dsr_n),
   .ring_indicator_n(ring_indicator_n),
   .carrier_detect_n(carrier_detect_n), .rts_n(rts_n), .dtr_n(dtr_n),
   .legacy_output_one_n(legacy_output_one_n), .op2_n(op2_n),
   .modem_irq(modem_irq));

// file: verif/ums_remote.sv
// Purpose: remote serial device facing the uart line
// Assumes: 16 clocks per bit, lsb first, line pulled high when idle
// Notes: decoder keeps only the last byte seen on tx
`timescale 1ns/1ns
module ums_remote (
   input wire logic clk,
   input wire logic tx,
   output logic rx,
   output logic [7:0] got
);
   initial begin
      rx = 1'b1;
      got = 8'h00;
   end
   // one idle clock after each frame so back-to-back calls never clash
   task automatic send_bits(input logic [9:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         rx <= f[i % 10];
         repeat (16) @(posedge clk);
      end
      rx <= 1'b1;
      @(posedge clk);
   endtask
   always begin
      @(negedge tx);
      repeat (24) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         got[i] = tx;
         repeat (16) @(posedge clk);
      end
   end
endmodule

// file: verif/tb.sv
// Purpose: self-checking bench for the uart line and modem status block
// Assumes: no parity unless set, fifo always on
// Notes: the overrun fill takes most of the run time
`timescale 1ns/1ns
module tb;
   logic clk, resetn, wr, rd, rx, tx, cts_n, dsr_n, ring_n, carr_n;
   logic rts_n, dtr_n, out1_n, op2_n, irq;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, got, v, m, q[$];
   logic [31:0] r;
   logic [1:0] pe;
   int seed, failures, n_compared;
   ums_uart_status i_dut (.clk(clk), .resetn(resetn), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx(rx), .tx(tx),
      .cts_n(cts_n), .dsr_n(dsr_n), .ring_indicator_n(ring_n),
      .carrier_detect_n(carr_n), .rts_n(rts_n), .dtr_n(dtr_n),
      .legacy_output_one_n(out1_n), .op2_n(op2_n), .modem_irq(irq));
   ums_remote i_rem (.clk(clk), .tx(tx), .rx(rx), .got(got));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask
   task automatic rchk(input logic [2:0] a, input logic [7:0] e, input string nm);
      logic [7:0] d;
      rd_reg(a, d);
      chk(nm, e, d);
   endtask
   task automatic frame(input logic [9:0] f, input int n);
      i_rem.send_bits(f, n);
      repeat (40) @(posedge clk);
   endtask
   function automatic logic [7:0] mcr_exp(input logic [7:0] o, d, input logic en);
      return en ? d : {o[7:5], d[4:0]};
   endfunction
   task automatic tally_and_finish;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      tally_and_finish();
   end
   initial begin
      seed = 59826;
      failures = 0;
      n_compared = 0;
      resetn = 1'b0;
      {wr, rd, addr, wdata} = 13'h0000;
      {cts_n, dsr_n, ring_n, carr_n} = 4'hF;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      rchk(ums_pkg::ADDR_MCR, 8'h00, "mcr");
      rchk(ums_pkg::ADDR_LSR, 8'h60, "lsr");
      rchk(ums_pkg::ADDR_MSR, 8'h00, "msr");
      m = 8'h00;
      for (int i = 0; i < 12; i++) begin
         r = $random(seed);
         if (i == 0)
            r = 32'h000000E3;
         wr_reg(ums_pkg::ADDR_EFR, {3'h0, r[8], 4'h0});
         wr_reg(ums_pkg::ADDR_MCR, r[7:0]);
         m = mcr_exp(m, r[7:0], r[8]);
         rchk(ums_pkg::ADDR_MCR, m, "mcr");
      end
      wr_reg(ums_pkg::ADDR_EFR, 8'h10);
      wr_reg(ums_pkg::ADDR_MCR, 8'h00);
      wr_reg(ums_pkg::ADDR_IER, 8'h08);
      // random loopback writes above may have left change flags set
      rd_reg(ums_pkg::ADDR_MSR, v);
      {cts_n, dsr_n, ring_n, carr_n} <= 4'h0;
      repeat (8) @(posedge clk);
      chk("irq", 8'h01, {7'h00, irq});
      rchk(ums_pkg::ADDR_MSR, 8'hFB, "msr");
      rchk(ums_pkg::ADDR_MSR, 8'hF0, "msr");
      chk("irq", 8'h00, {7'h00, irq});
      ring_n <= 1'b1;
      repeat (8) @(posedge clk);
      rchk(ums_pkg::ADDR_MSR, 8'hB4, "msr");
      wr_reg(ums_pkg::ADDR_IER, 8'h00);
      cts_n <= 1'b1;
      repeat (8) @(posedge clk);
      chk("irq", 8'h00, {7'h00, irq});
      rchk(ums_pkg::ADDR_MSR, 8'hA1, "msr");
      wr_reg(ums_pkg::ADDR_MCR, 8'h1F);
      // loopback bypasses the synchronisers; let the change flags settle
      repeat (8) @(posedge clk);
      rd_reg(ums_pkg::ADDR_MSR, v);
      rchk(ums_pkg::ADDR_MSR, 8'hF0, "msr");
      chk("outs", 8'h0F, {4'h0, op2_n, out1_n, rts_n, dtr_n});
      wr_reg(ums_pkg::ADDR_HOLD, 8'hA5);
      repeat (400) @(posedge clk);
      rchk(ums_pkg::ADDR_LSR, 8'h61, "lsr");
      rchk(ums_pkg::ADDR_HOLD, 8'hA5, "rx");
      wr_reg(ums_pkg::ADDR_MCR, 8'h00);
      wr_reg(ums_pkg::ADDR_EFR, 8'h90);
      // mode changes in the random loop can leave a stray byte in the model
      m = got;
      wr_reg(ums_pkg::ADDR_HOLD, 8'h3C);
      repeat (320) @(posedge clk);
      rd_reg(ums_pkg::ADDR_LSR, v);
      chk("temt", 8'h00, v & 8'h40);
      chk("tx", m, got);
      cts_n <= 1'b0;
      repeat (400) @(posedge clk);
      chk("tx", 8'h3C, got);
      rchk(ums_pkg::ADDR_LSR, 8'h60, "lsr");
      r = $random(seed);
      frame({1'b1, r[7:0], 1'b0}, 10);
      rchk(ums_pkg::ADDR_LSR, 8'h61, "lsr");
      rchk(ums_pkg::ADDR_HOLD, r[7:0], "rx");
      frame({1'b0, r[7:1], 1'b1, 1'b0}, 10);
      rchk(ums_pkg::ADDR_LSR, 8'hE9, "lsr");
      rchk(ums_pkg::ADDR_HOLD, {r[7:1], 1'b1}, "rx");
      rchk(ums_pkg::ADDR_LSR, 8'h60, "lsr");
      frame(10'h000, 25);
      rd_reg(ums_pkg::ADDR_LSR, v);
      chk("lsr", 8'hF1, v & 8'hF7);
      rchk(ums_pkg::ADDR_HOLD, 8'h00, "rx");
      rchk(ums_pkg::ADDR_LSR, 8'h60, "lsr");
      wr_reg(ums_pkg::ADDR_CTRL, 8'h02);
      for (int p = 0; p < 2; p++) begin
         frame({1'b1, p[0], 7'h2A, 1'b0}, 10);
         rd_reg(ums_pkg::ADDR_LSR, v);
         pe[p] = v[2];
         rd_reg(ums_pkg::ADDR_HOLD, v);
      end
      chk("par", 8'h01, {7'h00, pe[0] ^ pe[1]});
      wr_reg(ums_pkg::ADDR_CTRL, 8'h08);
      frame({1'b1, ums_pkg::XOFF_RESET, 1'b0}, 10);
      wr_reg(ums_pkg::ADDR_HOLD, 8'h55);
      repeat (200) @(posedge clk);
      rchk(ums_pkg::ADDR_LSR, 8'h00, "lsr");
      wr_reg(ums_pkg::ADDR_MCR, 8'h20);
      frame({1'b1, 8'h5A, 1'b0}, 10);
      repeat (200) @(posedge clk);
      rchk(ums_pkg::ADDR_LSR, 8'h61, "lsr");
      rchk(ums_pkg::ADDR_HOLD, 8'h5A, "rx");
      wr_reg(ums_pkg::ADDR_CTRL, 8'h00);
      for (int i = 0; i < 33; i++) begin
         r = $random(seed);
         q.push_back(r[7:0]);
         i_rem.send_bits({1'b1, r[7:0], 1'b0}, 10);
      end
      repeat (40) @(posedge clk);
      rchk(ums_pkg::ADDR_LSR, 8'h63, "lsr");
      for (int i = 0; i < 32; i++)
         rchk(ums_pkg::ADDR_HOLD, q[i], "rx");
      rchk(ums_pkg::ADDR_LSR, 8'h60, "lsr");
      wr_reg(ums_pkg::ADDR_MCR, 8'h40);
      repeat (40) @(posedge clk);
      chk("tx", 8'h00, {7'h00, tx});
      wr_reg(ums_pkg::ADDR_HOLD, 8'h00);
      repeat (200) @(posedge clk);
      chk("tx", 8'h00, {7'h00, tx});
      tally_and_finish();
   end
endmodule
